/* File: rcr_frame_if.sv */
// Purpose: Carries decoded serial frames between the port and the register bank.
// Assumes: One clock domain.
// Notes: The bank returns read data for rd_addr combinationally.
`timescale 1ns/1ps
interface rcr_frame_if;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [15:0] rd_data;
  logic cs_fall;
  logic sclk_edge;

  modport port (
    output wr_stb, wr_addr, wr_data, rd_addr, cs_fall, sclk_edge,
    input rd_data
  );
  modport bank (
    input wr_stb, wr_addr, wr_data, rd_addr, cs_fall, sclk_edge,
    output rd_data
  );
endinterface

/* File: rcr_host.sv */
// Purpose: Behavioural host that drives the serial register port.
// Assumes: Clock idles high, data sampled on rising, reads answer next frame.
// Notes: Eight system clocks per serial bit keeps every phase above the minimum.
`timescale 1ns/1ps
module rcr_host (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output logic o_cs_b,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge i_sys_clk);
    o_cs_b = 1'b0;
    wait_n(2);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = w[i];
      wait_n(4);
      r[i] = i_miso;
      o_sclk = 1'b1;
      wait_n(4);
    end
    o_cs_b = 1'b1;
    // A released data line must not keep looking valid.
    o_mosi = ~o_mosi;
    wait_n(2);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] x;
    xfer({1'b1, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    logic [15:0] x;
    xfer({1'b0, a, 8'h00}, x);
    xfer({1'b0, a, 8'h00}, r);
  endtask
endmodule

/* File: rcr_pkg.sv */
// Purpose: Shared constants and types for the recording control register bank.
// Assumes: Byte addresses on a 7-bit serial register address, 16-bit registers.
// Notes: Every offset, field position, reset value and count lives here.
package rcr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [6:0] ADDR_BIAS_LO = 7'h18;
  localparam logic [6:0] ADDR_BIAS_HI = 7'h19;
  localparam logic [6:0] ADDR_REC_LO = 7'h1a;
  localparam logic [6:0] ADDR_REC_HI = 7'h1b;
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [15:0] REC_RESET = 16'h1102;
  // Bits 14 and 4 are unused and always read as zero.
  localparam logic [15:0] REC_WMASK = 16'hbfef;

  // ****************************************************************
  // Recording control fields
  // ****************************************************************
  localparam int REC_TIMEOUT_BIT = 15;
  localparam int REC_WIN_LSB = 12;
  localparam int REC_RATE_LSB = 8;
  localparam int REC_PDOWN_BIT = 7;
  localparam int REC_STATS_BIT = 6;
  localparam int REC_VEL_BIT = 5;
  localparam int REC_STORE_LSB = 2;
  localparam int REC_MODE_LSB = 0;

  // ****************************************************************
  // Serial frame layout and timing counts
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WR_BIT = 15;
  localparam logic [2:0] STREAM_TIMEOUT_PERIODS = 3'd5;
  localparam logic [1:0] RATE_LAST_AT_RESET = 2'd3;

  typedef enum logic [1:0] {
    MODE_MANUAL_SPECTRUM = 2'b00,
    MODE_AUTO_SPECTRUM = 2'b01,
    MODE_TIME_CAPTURE = 2'b10,
    MODE_STREAMING = 2'b11
  } rcr_mode_e;

  typedef enum logic [1:0] {
    WIN_RECTANGULAR = 2'b00,
    WIN_HANNING = 2'b01,
    WIN_FLAT_TOP = 2'b10,
    WIN_UNUSED = 2'b11
  } rcr_window_e;

  typedef enum logic [1:0] {
    STORE_NONE = 2'b00,
    STORE_ON_ALARM = 2'b01,
    STORE_ALL = 2'b10,
    STORE_RESERVED = 2'b11
  } rcr_store_e;

endpackage

/* File: rcr_properties.sv */
// Purpose: Port-level checks of the recording control register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to rcr_regs from the testbench top file.
`timescale 1ns/1ps
module rcr_props (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic i_autonull_load,
  input wire logic [15:0] i_autonull_value,
  input wire logic i_capture_start,
  input wire logic i_capture_done,
  input wire logic i_alarm_exceeded,
  input wire logic i_timer_wake,
  input wire logic i_data_ready,
  input wire logic i_stream_pin,
  input wire logic [15:0] o_bias_correction,
  input wire logic [1:0] o_mode,
  input wire logic [1:0] o_window,
  input wire logic [1:0] o_rate_option,
  input wire logic o_rate_valid,
  input wire logic o_sleep,
  input wire logic o_stats_en,
  input wire logic o_velocity_en,
  input wire logic o_flash_store,
  input wire logic o_streaming
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_wake_req;
    $fell(i_cs_b) ##0 o_sleep;
  endsequence
  sequence s_done_stream;
    i_capture_done ##0 (o_mode == 2'b11);
  endsequence
  AST_BIAS_LOAD:
  assert property (i_autonull_load |=> o_bias_correction == $past(i_autonull_value))
    else $error("bias missed the auto-null value");
  AST_FLASH_CAUSE:
  assert property (o_flash_store |-> $past(i_capture_done))
    else $error("flash store without a finished capture");
  AST_FLASH_NO_STREAM:
  assert property (s_done_stream |=> !o_flash_store)
    else $error("flash store in streaming mode");
  AST_RATE_HOLD:
  assert property (!i_capture_start |=> $stable(o_rate_option))
    else $error("rate option moved without a capture");
  AST_RATE_STREAM:
  assert property (i_capture_start && o_mode == 2'b11 |=> $stable({o_rate_valid, o_rate_option}))
    else $error("rate rotation in streaming mode");
  AST_WIN_MODE:
  assert property ($past(o_mode[1]) && $past(i_rst_b) |-> o_window == 2'b00)
    else $error("window applied outside spectrum modes");
  AST_WIN_RESERVED:
  assert property (o_window != 2'b11)
    else $error("reserved window code reached the output");
  AST_STATS:
  assert property (o_stats_en |-> o_mode == 2'b10 || $past(o_mode) == 2'b10)
    else $error("statistics enabled outside time capture");
  AST_SLEEP_SET:
  assert property ($rose(o_sleep) |-> $past(i_capture_done))
    else $error("sleep entered without a finished capture");
  AST_CS_WAKE:
  assert property (s_wake_req |-> ##[1:4] !o_sleep)
    else $error("chip select did not wake the device");
  AST_TIMER_WAKE:
  assert property (i_timer_wake && !i_capture_done && o_sleep && o_mode == 2'b01 |=> !o_sleep)
    else $error("timer did not wake the device");
  AST_STREAM:
  assert property (o_streaming |-> $past(o_mode) == 2'b11 && $past(i_stream_pin))
    else $error("streaming without mode and pin");
endmodule

/* File: rcr_regs.sv */
// Purpose: Bias correction and recording control registers with their control effects.
// Assumes: All event inputs are one-cycle pulses synchronous to i_sys_clk.
// Notes: The spectrum, statistics and flash engines sit outside and obey these outputs.
`timescale 1ns/1ps
module rcr_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  input wire logic i_autonull_load,
  input wire logic [15:0] i_autonull_value,
  input wire logic i_capture_start,
  input wire logic i_capture_done,
  input wire logic i_alarm_exceeded,
  input wire logic i_timer_wake,
  input wire logic i_data_ready,
  input wire logic i_stream_pin,
  output logic [15:0] o_bias_correction,
  output logic [1:0] o_mode,
  output logic [1:0] o_window,
  output logic [1:0] o_rate_option,
  output logic o_rate_valid,
  output logic o_sleep,
  output logic o_stats_en,
  output logic o_velocity_en,
  output logic o_flash_store,
  output logic o_streaming
);

  // ****************************************************************
  // Serial port
  // ****************************************************************
  rcr_frame_if bus ();

  rcr_serial_port u_port (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b),
    .i_sclk(i_sclk),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .bus(bus)
  );

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0] bias_q, bias_d;
  logic [15:0] rec_q, rec_d;

  always_comb begin
    bias_d = bias_q;
    rec_d = rec_q;
    if (bus.wr_stb) begin
      unique case (bus.wr_addr)
        rcr_pkg::ADDR_BIAS_LO: bias_d[7:0] = bus.wr_data;
        rcr_pkg::ADDR_BIAS_HI: bias_d[15:8] = bus.wr_data;
        rcr_pkg::ADDR_REC_LO: rec_d[7:0] = bus.wr_data & rcr_pkg::REC_WMASK[7:0];
        rcr_pkg::ADDR_REC_HI: rec_d[15:8] = bus.wr_data & rcr_pkg::REC_WMASK[15:8];
        default: begin
        end
      endcase
    end
    // The auto-null result is the freshest estimate, so it wins a same-cycle write.
    if (i_autonull_load) begin
      bias_d = i_autonull_value;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bias_q <= rcr_pkg::BIAS_RESET;
      rec_q <= rcr_pkg::REC_RESET;
    end else begin
      bias_q <= bias_d;
      rec_q <= rec_d;
    end
  end

  always_comb begin
    unique case (bus.rd_addr[6:1])
      rcr_pkg::ADDR_BIAS_LO[6:1]: bus.rd_data = bias_q;
      rcr_pkg::ADDR_REC_LO[6:1]: bus.rd_data = rec_q;
      default: bus.rd_data = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  rcr_pkg::rcr_mode_e mode;
  logic [1:0] win_raw;
  logic [1:0] store_raw;
  logic [3:0] rate_en;
  logic capture_mode;
  logic timeout_en;

  always_comb begin
    mode = rcr_pkg::rcr_mode_e'(rec_q[rcr_pkg::REC_MODE_LSB +: 2]);
    win_raw = rec_q[rcr_pkg::REC_WIN_LSB +: 2];
    store_raw = rec_q[rcr_pkg::REC_STORE_LSB +: 2];
    rate_en = rec_q[rcr_pkg::REC_RATE_LSB +: 4];
    timeout_en = rec_q[rcr_pkg::REC_TIMEOUT_BIT];
    capture_mode = (mode != rcr_pkg::MODE_STREAMING);
  end

  // ****************************************************************
  // Rate option rotation
  // ****************************************************************
  logic [1:0] last_q, last_d;
  logic [1:0] rate_q, rate_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] next_opt;
  logic found;

  // Searching forward from the last used option covers one, two and four enables.
  always_comb begin
    next_opt = last_q;
    found = 1'b0;
    for (int k = 1; k <= 4; k++) begin
      if (!found && rate_en[2'(last_q + 2'(k))]) begin
        next_opt = 2'(last_q + 2'(k));
        found = 1'b1;
      end
    end
  end

  always_comb begin
    last_d = last_q;
    rate_d = rate_q;
    rvalid_d = rvalid_q;
    if (i_capture_start && capture_mode) begin
      rvalid_d = found;
      if (found) begin
        rate_d = next_opt;
        last_d = next_opt;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_q <= rcr_pkg::RATE_LAST_AT_RESET;
      rate_q <= 2'd0;
      rvalid_q <= 1'b0;
    end else begin
      last_q <= last_d;
      rate_q <= rate_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************************************
  // Sleep, record storage and streaming
  // ****************************************************************
  logic sleep_q, sleep_d;
  logic store_q, store_d;
  logic halted_q, halted_d;
  logic [2:0] idle_q, idle_d;
  logic drdy_q, drdy_d;
  logic stream_q, stream_d;

  always_comb begin
    sleep_d = sleep_q;
    if (bus.cs_fall) begin
      sleep_d = 1'b0;
    end
    if (i_timer_wake && mode == rcr_pkg::MODE_AUTO_SPECTRUM) begin
      sleep_d = 1'b0;
    end
    // The set is checked last so a record that finishes in a wake cycle is not lost.
    if (i_capture_done && capture_mode && rec_q[rcr_pkg::REC_PDOWN_BIT]) begin
      sleep_d = 1'b1;
    end
  end

  always_comb begin
    store_d = 1'b0;
    if (i_capture_done && capture_mode) begin
      unique case (store_raw)
        rcr_pkg::STORE_ON_ALARM: store_d = i_alarm_exceeded;
        rcr_pkg::STORE_ALL: store_d = 1'b1;
        default: store_d = 1'b0;
      endcase
    end
  end

  // A ready period counts as missed when it rises with no serial clock since the last.
  always_comb begin
    drdy_d = i_data_ready;
    idle_d = idle_q;
    halted_d = halted_q;
    if (bus.sclk_edge) begin
      idle_d = 3'd0;
    end else if (i_data_ready && !drdy_q && stream_q) begin
      idle_d = (idle_q == rcr_pkg::STREAM_TIMEOUT_PERIODS) ? idle_q : idle_q + 3'd1;
    end
    if (timeout_en && idle_q == rcr_pkg::STREAM_TIMEOUT_PERIODS) begin
      halted_d = 1'b1;
    end
    // The halt holds until the host releases the stream pin or the mode leaves streaming.
    if (!i_stream_pin || mode != rcr_pkg::MODE_STREAMING) begin
      halted_d = 1'b0;
      idle_d = 3'd0;
    end
    stream_d = (mode == rcr_pkg::MODE_STREAMING) && i_stream_pin && !halted_d;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_q <= 1'b0;
      store_q <= 1'b0;
      halted_q <= 1'b0;
      idle_q <= 3'd0;
      drdy_q <= 1'b0;
      stream_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      store_q <= store_d;
      halted_q <= halted_d;
      idle_q <= idle_d;
      drdy_q <= drdy_d;
      stream_q <= stream_d;
    end
  end

  // ****************************************************************
  // Registered configuration outputs
  // ****************************************************************
  logic [1:0] win_q, win_d;
  logic stats_q, stats_d;
  logic vel_q, vel_d;

  always_comb begin
    win_d = rcr_pkg::WIN_RECTANGULAR;
    if (mode == rcr_pkg::MODE_MANUAL_SPECTRUM || mode == rcr_pkg::MODE_AUTO_SPECTRUM) begin
      win_d = (win_raw == rcr_pkg::WIN_UNUSED) ? rcr_pkg::WIN_RECTANGULAR : win_raw;
    end
    stats_d = rec_q[rcr_pkg::REC_STATS_BIT] && mode == rcr_pkg::MODE_TIME_CAPTURE;
    vel_d = rec_q[rcr_pkg::REC_VEL_BIT];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      win_q <= rcr_pkg::WIN_HANNING;
      stats_q <= 1'b0;
      vel_q <= 1'b0;
    end else begin
      win_q <= win_d;
      stats_q <= stats_d;
      vel_q <= vel_d;
    end
  end

  assign o_bias_correction = bias_q;
  assign o_mode = rec_q[rcr_pkg::REC_MODE_LSB +: 2];
  assign o_window = win_q;
  assign o_rate_option = rate_q;
  assign o_rate_valid = rvalid_q;
  assign o_sleep = sleep_q;
  assign o_stats_en = stats_q;
  assign o_velocity_en = vel_q;
  assign o_flash_store = store_q;
  assign o_streaming = stream_q;

endmodule

/* File: rcr_serial_port.sv */
// Purpose: Serial register port, 16-bit frames, clock idle high, sample on rising.
// Assumes: Serial pins are synchronous to i_sys_clk and sclk is at most a quarter of it.
// Notes: A read frame returns its data during the following frame.
`timescale 1ns/1ps
module rcr_serial_port (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  rcr_frame_if.port bus
);

  logic cs_b_q, cs_b_d;
  logic sclk_q, sclk_d;
  logic [15:0] shift_q, shift_d;
  logic [15:0] tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic miso_q, miso_d;
  logic wr_q, wr_d;
  logic [6:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic [6:0] ra_q, ra_d;
  logic fall_q, fall_d;
  logic edge_q, edge_d;
  logic [15:0] frame;

  always_comb begin
    cs_b_d = i_cs_b;
    sclk_d = i_sclk;
    shift_d = shift_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    miso_d = miso_q;
    wr_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    ra_d = ra_q;
    fall_d = cs_b_q & ~i_cs_b;
    edge_d = 1'b0;
    frame = {shift_q[14:0], i_mosi};
    if (i_cs_b) begin
      cnt_d = 4'd0;
    end else if (cs_b_q) begin
      // Preload the answer so its top bit is valid before the first edge.
      tx_d = {bus.rd_data[14:0], 1'b0};
      miso_d = bus.rd_data[15];
    end else if (sclk_q & ~i_sclk) begin
      if (cnt_q != 4'd0) begin
        miso_d = tx_q[15];
        tx_d = {tx_q[14:0], 1'b0};
      end
    end else if (~sclk_q & i_sclk) begin
      edge_d = 1'b1;
      shift_d = frame;
      cnt_d = cnt_q + 4'd1;
      if (cnt_q == 4'(rcr_pkg::FRAME_BITS - 1)) begin
        if (frame[rcr_pkg::FRAME_WR_BIT]) begin
          wr_d = 1'b1;
          wa_d = frame[14:8];
          wd_d = frame[7:0];
        end else begin
          ra_d = frame[14:8];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_b_q <= 1'b1;
      sclk_q <= 1'b1;
      shift_q <= 16'h0000;
      tx_q <= 16'h0000;
      cnt_q <= 4'd0;
      miso_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 7'h00;
      wd_q <= 8'h00;
      ra_q <= 7'h00;
      fall_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      cs_b_q <= cs_b_d;
      sclk_q <= sclk_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      miso_q <= miso_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ra_q <= ra_d;
      fall_q <= fall_d;
      edge_q <= edge_d;
    end
  end

  assign o_miso = miso_q;
  assign bus.wr_stb = wr_q;
  assign bus.wr_addr = wa_q;
  assign bus.wr_data = wd_q;
  assign bus.rd_addr = ra_q;
  assign bus.cs_fall = fall_q;
  assign bus.sclk_edge = edge_q;

endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the recording control register bank.
// Assumes: Host model drives the serial pins, events are one-cycle pulses.
// Notes: Expected values go through a queue checked by a separate process.
`timescale 1ns/1ps
bind rcr_regs rcr_props u_props (.*);
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cs_b, sclk, mosi, miso, rval, slp, stats, vel, fst, strm;
  logic ld = 0, st = 0, dn = 0, al = 0, tw = 0, dr = 0, pin = 0;
  logic [15:0] av = 16'h0000;
  logic [15:0] bias, got_v;
  logic [1:0] mode, win, ropt;
  logic [1:0] last = 2'd3;
  logic [15:0] exp_q[$];
  logic [5:0] plan[5] = '{6'b0001_10, 6'b0100_00, 6'b0110_01, 6'b1111_10, 6'b0000_10};
  int fail_count = 0;
  int comparisons = 0;
  event got;
  always #20 i_sys_clk = ~i_sys_clk;
  rcr_regs u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sclk(sclk),
    .i_mosi(mosi), .o_miso(miso), .i_autonull_load(ld), .i_autonull_value(av),
    .i_capture_start(st), .i_capture_done(dn), .i_alarm_exceeded(al), .i_timer_wake(tw),
    .i_data_ready(dr), .i_stream_pin(pin), .o_bias_correction(bias), .o_mode(mode),
    .o_window(win), .o_rate_option(ropt), .o_rate_valid(rval), .o_sleep(slp),
    .o_stats_en(stats), .o_velocity_en(vel), .o_flash_store(fst), .o_streaming(strm));
  rcr_host u_host (.i_sys_clk(i_sys_clk), .i_miso(miso), .o_cs_b(cs_b), .o_sclk(sclk),
    .o_mosi(mosi));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  always @(got) begin
    logic [15:0] e;
    e = exp_q.pop_front();
    comparisons++;
    if (got_v !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, e);
    end
  end
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    exp_q.push_back(e);
    got_v = v;
    ->got;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic rdy(input int n);
    repeat (n) begin
      dr = 1'b1;
      cyc(2);
      dr = 1'b0;
      cyc(2);
    end
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    u_host.wr(a, v[7:0]);
    u_host.wr(a + 7'd1, v[15:8]);
    cyc(4);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] r;
    u_host.rd(a, r);
    chk(r, e);
  endtask
  // Next enabled option after the last one used, wrapping round.
  function automatic logic [1:0] nxt(input logic [3:0] en, input logic [1:0] l);
    logic [1:0] c;
    c = l;
    for (int i = 0; i < 4; i++) begin
      c = c + 2'd1;
      if (en[c]) return c;
    end
    return l;
  endfunction
  task automatic wrap_up();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #2400000;
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [15:0] v;
    void'($urandom(97412));
    cyc(4);
    i_rst_b = 1'b1;
    cyc(2);
    rdchk(7'h18, rcr_pkg::BIAS_RESET);
    rdchk(7'h1a, rcr_pkg::REC_RESET);
    $display("reset values done");
    v = 16'($urandom);
    wr16(7'h18, v);
    rdchk(7'h18, v);
    chk(bias, v);
    wr16(7'h40, 16'hffff);
    rdchk(7'h40, 16'h0000);
    wr16(7'h1a, 16'hffff);
    rdchk(7'h1a, 16'hffff & rcr_pkg::REC_WMASK);
    av = 16'($urandom);
    pulse(ld);
    chk(bias, av);
    $display("register access done");
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 4; w++) begin
        wr16(7'h1a, {2'b00, w[1:0], 10'h040, m[1:0]});
        chk({12'h0, mode, win}, {12'h0, m[1:0], (m[1] || w == 3) ? 2'b00 : w[1:0]});
      end
    end
    $display("window and mode done");
    foreach (plan[k]) begin
      wr16(7'h1a, {4'h0, plan[k][5:2], 6'h00, plan[k][1:0]});
      repeat (5) begin
        pulse(st);
        last = nxt(plan[k][5:2], last);
        chk({13'h0, rval, ropt}, {13'h0, plan[k][5:2] != 4'h0, last});
      end
    end
    wr16(7'h1a, 16'h0f03);
    pulse(st);
    chk({13'h0, rval, ropt}, {13'h0, 1'b0, last});
    $display("rate rotation done");
    for (int s = 0; s < 8; s++) begin
      wr16(7'h1a, {8'h01, 1'b1, 3'b000, s[1:0], 2'b10});
      al = s[2];
      pulse(dn);
      chk({14'h0, fst, slp}, {14'h0, s[1:0] == 2 || (s[1:0] == 1 && s[2]), 1'b1});
      rdchk(7'h1a, {8'h01, 1'b1, 3'b000, s[1:0], 2'b10});
      chk({15'h0, slp}, 16'h0000);
    end
    wr16(7'h1a, 16'h010b);
    pulse(dn);
    chk({14'h0, fst, slp}, 16'h0000);
    wr16(7'h1a, 16'h0181);
    pulse(dn);
    pulse(tw);
    chk({15'h0, slp}, 16'h0000);
    $display("storage and sleep done");
    wr16(7'h1a, 16'h0162);
    chk({14'h0, stats, vel}, 16'h0003);
    wr16(7'h1a, 16'h0120);
    chk({14'h0, stats, vel}, 16'h0001);
    wr16(7'h1a, 16'h0140);
    chk({14'h0, stats, vel}, 16'h0000);
    $display("statistics and velocity done");
    wr16(7'h1a, 16'h0103);
    pin = 1'b1;
    rdy(7);
    chk({15'h0, strm}, 16'h0001);
    pin = 1'b0;
    cyc(3);
    chk({15'h0, strm}, 16'h0000);
    wr16(7'h1a, 16'h8103);
    pin = 1'b1;
    rdy(4);
    rdchk(7'h1a, 16'h8103);
    rdy(4);
    chk({15'h0, strm}, 16'h0001);
    rdy(1);
    cyc(3);
    chk({15'h0, strm}, 16'h0000);
    pin = 1'b0;
    $display("streaming done");
    wrap_up();
  end
endmodule
